// [hdl/usbt_pkg.sv]
package usbt_pkg;
  // --------------------------------------------------------------
  // register indices (byte address is four times the index)
  // --------------------------------------------------------------
  localparam logic [13:0] SEL_IDX = 14'h040F;
  localparam logic [13:0] CTRL_IDX = 14'h0401;
  localparam logic [13:0] CSR_IDX = 14'h0402;
  localparam logic [13:0] ROLE_IDX = 14'h0403;
  localparam logic [13:0] FIFO_IDX = 14'h0404;
  localparam logic [13:0] IST_IDX = 14'h0405;
  localparam logic [13:0] ICLR_IDX = 14'h0406;
  localparam logic [13:0] IEN_IDX = 14'h0407;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int SEL_NAK = 0;
  localparam int SEL_J = 1;
  localparam int SEL_K = 2;
  localparam int SEL_PKT = 3;
  localparam int SEL_HS = 4;
  localparam int SEL_FS = 5;
  localparam int SEL_LOOP = 6;
  localparam int SEL_HOST = 7;
  localparam int CTRL_SOFT_RST = 0;
  localparam int CSR_RXRDY = 0;
  localparam int CSR_TXRDY = 1;
  localparam int CSR_SERVICED = 6;
  localparam int ROLE_SESSION = 0;
  localparam int ROLE_HOST = 2;
  localparam int ROLE_DISC = 7;
  localparam int IRQ_EP0 = 0;
  localparam int IRQ_PKT = 1;
  localparam int IRQ_DISC = 2;

  // --------------------------------------------------------------
  // codes and reset values
  // --------------------------------------------------------------
  localparam logic [7:0] PID_DATA0 = 8'hC3;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int EP0_DEPTH = 64;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_PID = 3'b001,
    TX_DATA = 3'b010,
    TX_CRC_LO = 3'b011,
    TX_CRC_HI = 3'b100
  } usbt_tx_e;
endpackage

// [hdl/usbt_test_modes.sv]
// Function
// (R1) nak-all code: every valid IN token answered with NAK.
// (R2) J code: continuous J driven while mode is held.
// (R3) K code: continuous K driven while mode is held.
// (R4) test-packet code: endpoint-0 packet resent forever after one load.
// (R5) software loads 53-byte pattern once; content kept for every repeat.
// (R6) software: session, load, write packet code, then set tx-ready.
// (R7) each test packet carries DATA0 PID first and CRC last.
// (R8) software writes selector only after endpoint-0 status phase ends.
// (R9) loopback code: copy pointer, reset cpu pointer, tx off, rx on, irq.
// (R10) loopback handles 64 bytes; tx and rx share one RAM.
// (R11) software: load, tx-ready, loopback code, read back, serviced.
// (R12) forced-host bit: host role ignoring id, line state, disconnect.
// (R13) forced-host: host with session, held until session clears.
// (R14) forced-host: disconnect shown in top bit of role register.
// (R15) forced-host: speed from forced high/full speed bits.
// (R16) hardware or soft reset clears the selector to zero.
`timescale 1ns/1ps
module usbt_test_modes
  import usbt_pkg::*;
#(
  parameter int DEPTH = EP0_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  input wire logic in_token,
  output logic nak_handshake,
  output logic line_oe,
  output logic line_dp,
  output logic line_dm,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic role_id_input,
  input wire logic [1:0] line_state_bus,
  input wire logic host_disconnect_flag,
  output logic host_mode,
  output logic speed_high,
  output logic speed_full
);
  localparam int PW = $clog2(DEPTH) + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] ONE_P = PW'(1);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [13:0] waddr;
    logic [7:0] wbyte;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } usbt_bus_s;
  typedef struct packed {
    logic [7:0] sel;
    logic txrdy;
    logic rxrdy;
    logic [PW-1:0] cpu_ptr;
    logic [PW-1:0] usb_ptr;
    logic [PW-1:0] rx_idx;
    logic [DEPTH-1:0][7:0] mem;
    logic session;
    logic host;
    logic disc;
    logic [2:0] ist;
    logic [2:0] ien;
    logic irq;
    usbt_tx_e tx_st;
    logic [PW-1:0] tx_idx;
    logic [15:0] crc;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic nak;
    logic line_oe;
    logic line_dp;
    logic line_dm;
    logic spd_hs;
    logic spd_fs;
  } usbt_core_s;
  typedef struct packed {
    usbt_bus_s b;
    usbt_core_s c;
  } usbt_state_s;
  localparam usbt_bus_s BUS_RST = '{awready: 1'b1, wready: 1'b1,
                                    arready: 1'b1, default: '0};
  usbt_state_s s_r;
  usbt_state_s s_nxt;
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                             input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ CRC_POLY_REFL;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction
  function automatic logic is_mapped(input logic [13:0] idx);
    return idx inside {SEL_IDX, CTRL_IDX, CSR_IDX, ROLE_IDX, FIFO_IDX,
                       IST_IDX, ICLR_IDX, IEN_IDX};
  endfunction
  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic do_wr;
    logic soft_rst;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [7:0] wd;
    logic [13:0] ridx;
    logic [15:0] crc_new;
    do_wr = s_r.b.aw_held && s_r.b.w_held && !s_r.b.bvalid;
    soft_rst = 1'b0;
    ev = 3'h0;
    clr = 3'h0;
    wd = s_r.b.wbyte;
    ridx = s_axi_araddr[15:2];
    crc_new = 16'h0000;
    s_nxt = s_r;
    // write address and data are taken in either order
    if (s_r.b.awready && s_axi_awvalid) begin
      s_nxt.b.awready = 1'b0;
      s_nxt.b.aw_held = 1'b1;
      s_nxt.b.waddr = s_axi_awaddr[15:2];
    end
    if (s_r.b.wready && s_axi_wvalid) begin
      s_nxt.b.wready = 1'b0;
      s_nxt.b.w_held = 1'b1;
      s_nxt.b.wbyte = s_axi_wdata[7:0];
      s_nxt.b.wlane0 = s_axi_wstrb[0];
    end
    if (do_wr) begin
      s_nxt.b.aw_held = 1'b0;
      s_nxt.b.w_held = 1'b0;
      s_nxt.b.bvalid = 1'b1;
      s_nxt.b.bresp = is_mapped(s_r.b.waddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_r.b.bvalid && s_axi_bready) begin
      s_nxt.b.bvalid = 1'b0;
      s_nxt.b.awready = 1'b1;
      s_nxt.b.wready = 1'b1;
    end
    // register write effects; a write with lane 0 off stores nothing
    if (do_wr && s_r.b.wlane0) begin
      unique case (s_r.b.waddr)
        SEL_IDX: begin
          s_nxt.c.sel = wd;
          if (wd[SEL_LOOP]) begin
            // (R9) loopback sequence
            s_nxt.c.usb_ptr = s_r.c.cpu_ptr;
            s_nxt.c.cpu_ptr = '0;
            s_nxt.c.txrdy = 1'b0;
            s_nxt.c.rxrdy = 1'b1;
            s_nxt.c.rx_idx = '0;
            ev[IRQ_EP0] = 1'b1;
          end
        end
        CTRL_IDX: soft_rst = wd[CTRL_SOFT_RST];
        CSR_IDX: begin
          if (wd[CSR_TXRDY]) begin
            s_nxt.c.txrdy = 1'b1;
          end
          if (wd[CSR_SERVICED]) begin
            s_nxt.c.rxrdy = 1'b0;
            s_nxt.c.usb_ptr = '0;
            s_nxt.c.rx_idx = '0;
          end
        end
        ROLE_IDX: s_nxt.c.session = wd[ROLE_SESSION];
        FIFO_IDX: begin
          // (R10) one RAM serves tx loading and rx reading
          if (s_r.c.cpu_ptr < DEPTH_P) begin
            s_nxt.c.mem[s_r.c.cpu_ptr[PW-2:0]] = wd;
            s_nxt.c.cpu_ptr = s_r.c.cpu_ptr + ONE_P;
          end
        end
        ICLR_IDX: clr = wd[2:0];
        IEN_IDX: s_nxt.c.ien = wd[2:0];
        default: ;
      endcase
    end
    // read answers one cycle after the address is taken
    if (s_r.b.arready && s_axi_arvalid) begin
      s_nxt.b.arready = 1'b0;
      s_nxt.b.rvalid = 1'b1;
      s_nxt.b.rdata = 32'h0000_0000;
      s_nxt.b.rresp = is_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
      unique case (ridx)
        SEL_IDX: s_nxt.b.rdata[7:0] = s_r.c.sel;
        CSR_IDX: begin
          s_nxt.b.rdata[CSR_RXRDY] = s_r.c.rxrdy;
          s_nxt.b.rdata[CSR_TXRDY] = s_r.c.txrdy;
        end
        ROLE_IDX: begin
          s_nxt.b.rdata[ROLE_SESSION] = s_r.c.session;
          s_nxt.b.rdata[ROLE_HOST] = s_r.c.host;
          // (R14) disconnect reflected in top bit
          s_nxt.b.rdata[ROLE_DISC] = s_r.c.disc;
        end
        FIFO_IDX: begin
          // pop reads what loopback handed over; empty reads zero
          if (s_r.c.rx_idx < s_r.c.usb_ptr) begin
            s_nxt.b.rdata[7:0] = s_r.c.mem[s_r.c.rx_idx[PW-2:0]];
            s_nxt.c.rx_idx = s_r.c.rx_idx + ONE_P;
          end
        end
        IST_IDX: s_nxt.b.rdata[2:0] = s_r.c.ist;
        IEN_IDX: s_nxt.b.rdata[2:0] = s_r.c.ien;
        default: ;
      endcase
    end
    if (s_r.b.rvalid && s_axi_rready) begin
      s_nxt.b.rvalid = 1'b0;
      s_nxt.b.arready = 1'b1;
    end
    // (R1) nak every in token while nak-all is selected
    s_nxt.c.nak = s_r.c.sel[SEL_NAK] && in_token;
    // line drive: J beats K if software sets both
    s_nxt.c.line_oe = s_r.c.sel[SEL_J] || s_r.c.sel[SEL_K];
    // (R2) continuous J
    s_nxt.c.line_dp = s_r.c.sel[SEL_J];
    // (R3) continuous K
    s_nxt.c.line_dm = s_r.c.sel[SEL_K] && !s_r.c.sel[SEL_J];
    // test packet sender; a started packet always finishes unless a soft reset
    // clears it, so a selector change never drops valid mid-packet
    unique case (s_r.c.tx_st)
      TX_IDLE: begin
        // (R4) restart as long as the mode and tx-ready are held and neither J nor K is being driven
        if (s_r.c.sel[SEL_PKT] && s_r.c.txrdy && !s_r.c.line_oe) begin
          // (R7) DATA0 pid leads
          s_nxt.c.tx_data = PID_DATA0;
          s_nxt.c.tx_valid = 1'b1;
          s_nxt.c.tx_st = TX_PID;
          s_nxt.c.crc = CRC_INIT;
        end
      end
      TX_PID: begin
        if (tx_ready) begin
          if (s_r.c.cpu_ptr == '0) begin
            s_nxt.c.tx_data = ~s_r.c.crc[7:0];
            s_nxt.c.tx_st = TX_CRC_LO;
          end else begin
            // (R5) fifo content is read, never consumed
            s_nxt.c.tx_data = s_r.c.mem[0];
            s_nxt.c.tx_idx = ONE_P;
            s_nxt.c.tx_st = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (tx_ready) begin
          crc_new = crc16_byte(s_r.c.crc, s_r.c.tx_data);
          s_nxt.c.crc = crc_new;
          if (s_r.c.tx_idx >= s_r.c.cpu_ptr) begin
            // (R7) crc trails, low byte first
            s_nxt.c.tx_data = ~crc_new[7:0];
            s_nxt.c.tx_st = TX_CRC_LO;
          end else begin
            s_nxt.c.tx_data = s_r.c.mem[s_r.c.tx_idx[PW-2:0]];
            s_nxt.c.tx_idx = s_r.c.tx_idx + ONE_P;
          end
        end
      end
      TX_CRC_LO: begin
        if (tx_ready) begin
          s_nxt.c.tx_data = ~s_r.c.crc[15:8];
          s_nxt.c.tx_last = 1'b1;
          s_nxt.c.tx_st = TX_CRC_HI;
        end
      end
      TX_CRC_HI: begin
        if (tx_ready) begin
          s_nxt.c.tx_valid = 1'b0;
          s_nxt.c.tx_last = 1'b0;
          s_nxt.c.tx_data = 8'h00;
          s_nxt.c.tx_st = TX_IDLE;
          ev[IRQ_PKT] = 1'b1;
        end
      end
      default: s_nxt.c.tx_st = TX_IDLE;
    endcase
    // role and speed
    if (s_r.c.sel[SEL_HOST]) begin
      // (R12) id, line state and disconnect ignored
      // (R13) host follows the session bit alone
      s_nxt.c.host = s_r.c.session;
      s_nxt.c.disc = host_disconnect_flag;
      // (R15) forced speed bits
      s_nxt.c.spd_hs = s_r.c.sel[SEL_HS];
      s_nxt.c.spd_fs = s_r.c.sel[SEL_FS];
      ev[IRQ_DISC] = host_disconnect_flag && !s_r.c.disc;
    end else begin
      s_nxt.c.host = s_r.c.session && !role_id_input &&
                     line_state_bus != LINE_SE0 && !host_disconnect_flag;
      s_nxt.c.disc = 1'b0;
      s_nxt.c.spd_hs = 1'b0;
      s_nxt.c.spd_fs = 1'b0;
    end
    // sticky status; a new event wins over a clear in the same cycle
    s_nxt.c.ist = (s_r.c.ist & ~clr) | ev;
    s_nxt.c.irq = |(s_nxt.c.ist & s_r.c.ien);
    // (R16) soft reset clears the selector and all core state; bus handshake state is kept
    if (soft_rst) begin
      s_nxt.c = '0;
    end
  end
  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // (R16) hardware reset leaves no test mode active
      s_r.b <= BUS_RST;
      s_r.c <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // outputs straight from the state flops
  assign {s_axi_awready, s_axi_wready, s_axi_arready} =
    {s_r.b.awready, s_r.b.wready, s_r.b.arready};
  assign {s_axi_bvalid, s_axi_bresp, s_axi_rvalid, s_axi_rresp} =
    {s_r.b.bvalid, s_r.b.bresp, s_r.b.rvalid, s_r.b.rresp};
  assign s_axi_rdata = s_r.b.rdata;
  assign {irq, nak_handshake, line_oe, line_dp, line_dm} =
    {s_r.c.irq, s_r.c.nak, s_r.c.line_oe, s_r.c.line_dp, s_r.c.line_dm};
  assign {tx_valid, tx_data, tx_last, host_mode, speed_high, speed_full} =
    {s_r.c.tx_valid, s_r.c.tx_data, s_r.c.tx_last, s_r.c.host,
     s_r.c.spd_hs, s_r.c.spd_fs};
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import usbt_pkg::*;
;
  logic aclk = 0, aresetn = 0, in_token = 0, stall = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, role_id_input = 0;
  logic host_disconnect_flag = 0;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0, crc;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat, lf = 74897;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] line_state_bus = 2'h0, rsp, s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, nak_handshake, line_oe, line_dp, line_dm;
  logic tx_valid, tx_last, tx_ready, host_mode, speed_high, speed_full;
  logic [7:0] tx_data, mem [0:63];
  int fail_count = 0, compares = 0;

  usbt_test_modes #(.DEPTH(EP0_DEPTH)) usbt_test_modes_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq, .in_token, .nak_handshake, .line_oe, .line_dp, .line_dm,
    .tx_valid, .tx_data, .tx_last, .tx_ready, .role_id_input,
    .line_state_bus, .host_disconnect_flag, .host_mode, .speed_high,
    .speed_full);
  usbt_phy_model usbt_phy_model_i (.aclk, .aresetn, .tx_valid, .tx_data,
    .tx_last, .stall, .tx_ready);

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  always #10 aclk = ~aclk;
  // maximal-length taps so the stall pattern never locks up
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // random far-side stalls, also the byte source
  always @(posedge aclk) begin
    lf <= lfsr_next(lf);
    stall <= lf[5];
  end
  function automatic logic [7:0] pat(int k);
    logic [127:0] t;
    t = 128'h7FBFDFEFF7FBFDFC7EBFDFEFF7FBFD7E;
    if (k < 9) return 8'h00;
    if (k < 17) return 8'hAA;
    if (k < 25) return 8'hEE;
    if (k < 26) return 8'hFE;
    if (k < 37) return 8'hFF;
    return t[127 - 8 * (k - 37) -: 8];
  endfunction
  function automatic logic [15:0] crc16();
    logic [15:0] c;
    c = CRC_INIT;
    for (int k = 0; k < 53; k++) begin
      c = c ^ 16'(pat(k));
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
    end
    return ~c;
  endfunction
  function automatic logic [7:0] exp_byte(int k, logic [15:0] c);
    if (k == 0) return PID_DATA0;
    if (k < 54) return pat(k - 1);
    return k == 54 ? c[7:0] : c[15:8];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tmo;
    fail_count++;
    $display("ERROR %0t timeout", $time);
    wrap_up();
  endtask
  // one write: address and data offered together, dropped when taken
  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {lf[31:8], d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 0;
        return;
      end
    end
    tmo();
  endtask
  task automatic rd(input logic [13:0] i);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 0;
        return;
      end
    end
    tmo();
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd(SEL_IDX);
    chk(rdat, SEL_RESET);
    rd(14'h0000);
    chk(rsp, RESP_SLVERR);
    wr(14'h0000, 8'h00);
    chk(rsp, RESP_SLVERR);
    // token answered only in nak-all mode
    for (int j = 0; j < 2; j++) begin
      wr(SEL_IDX, 8'(1 - j));
      in_token <= 1;
      @(posedge aclk);
      in_token <= 0;
      @(posedge aclk);
      chk(nak_handshake, 1 - j);
    end
    for (int j = 1; j < 3; j++) begin
      wr(SEL_IDX, 8'(1 << j));
      repeat (8) @(posedge aclk)
        chk({line_oe, line_dp, line_dm}, {1'b1, j == 1, j == 2});
    end
    wr(CTRL_IDX, 8'h01);
    rd(SEL_IDX);
    chk({rdat[7:0], line_oe}, 0);
    // full fifo plus one extra byte that must be dropped
    for (int k = 0; k < 64; k++) begin
      mem[k] = lf[7:0];
      wr(FIFO_IDX, mem[k]);
    end
    wr(FIFO_IDX, 8'hA5);
    wr(CSR_IDX, 8'h02);
    chk(rsp, RESP_OKAY);
    wr(SEL_IDX, 8'h40);
    rd(CSR_IDX);
    chk({rdat[1:0], irq}, 3'b010);
    rd(IST_IDX);
    chk(rdat[0], 1);
    wr(IEN_IDX, 8'h01);
    repeat (2) @(posedge aclk);
    chk(irq, 1);
    for (int k = 0; k < 65; k++) begin
      rd(FIFO_IDX);
      chk(rdat, k < 64 ? 32'(mem[k]) : 0);
    end
    wr(CSR_IDX, 8'h40);
    wr(ICLR_IDX, 8'h01);
    rd(CSR_IDX);
    chk({rdat[0], irq}, 0);
    // forced host ignores id, line state and disconnect
    role_id_input <= 1;
    host_disconnect_flag <= 1;
    wr(SEL_IDX, 8'h90);
    wr(ROLE_IDX, 8'h01);
    rd(ROLE_IDX);
    chk({host_mode, speed_high, speed_full, rdat[7]}, 4'hD);
    wr(SEL_IDX, 8'hA0);
    repeat (3) @(posedge aclk);
    chk({host_mode, speed_high, speed_full}, 3'b101);
    wr(SEL_IDX, 8'h00);
    repeat (3) @(posedge aclk);
    chk({host_mode, speed_high, speed_full}, 0);
    wr(SEL_IDX, 8'h80);
    wr(ROLE_IDX, 8'h00);
    repeat (3) @(posedge aclk);
    chk(host_mode, 0);
    // repeating test packet with a stalling receiver
    wr(SEL_IDX, 8'h00);
    wr(ROLE_IDX, 8'h01);
    for (int k = 0; k < 53; k++) wr(FIFO_IDX, pat(k));
    wr(SEL_IDX, 8'h08);
    wr(CSR_IDX, 8'h02);
    for (int n = 0; n < 3000 && usbt_phy_model_i.pkts < 2; n++)
      @(posedge aclk);
    if (usbt_phy_model_i.pkts < 2) tmo();
    crc = crc16();
    for (int p = 0; p < 112; p++)
      chk(usbt_phy_model_i.cap[p], exp_byte(p % 56, crc));
    rd(IST_IDX);
    chk(rdat[1], 1);
    wr(SEL_IDX, 8'h00);
    wrap_up();
  end
endmodule

// [sim/usbt_phy_model.sv]
`timescale 1ns/1ps
module usbt_phy_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic stall,
  output logic tx_ready
);
  logic [7:0] cap [0:127];
  int nb;
  int pkts;
  // stalls come from the bench so they are repeatable
  assign tx_ready = !stall;
  // keep the first two packets, count all of them
  always @(posedge aclk) begin
    if (!aresetn) begin
      nb <= 0;
      pkts <= 0;
    end else if (tx_valid && tx_ready) begin
      if (nb < 128) cap[nb] <= tx_data;
      nb <= nb + 1;
      if (tx_last) pkts <= pkts + 1;
    end
  end
endmodule

// [sim/usbt_properties.sv]
`timescale 1ns/1ps
module usbt_properties
  import usbt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic in_token,
  input wire logic nak_handshake,
  input wire logic line_oe,
  input wire logic line_dp,
  input wire logic line_dm,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic speed_high,
  input wire logic speed_full
);
  // ----------------------------------------------------------
  // port relations
  // ----------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence byte_taken;
    tx_valid && tx_ready;
  endsequence
  sequence byte_stalled;
    tx_valid && !tx_ready;
  endsequence
  sequence last_taken;
    byte_taken ##0 tx_last;
  endsequence
  nak_after_token_a: assert property (
    nak_handshake |-> $past(in_token)) else $error("nak without token");
  nak_single_a: assert property (
    nak_handshake && !in_token |=> !nak_handshake) else $error("nak long");
  // pins move a cycle after a write answer; soft reset acts at once
  line_unbroken_a: assert property (
    $changed({line_oe, line_dp, line_dm}) |->
      $past(s_axi_bvalid) || $rose(s_axi_bvalid))
    else $error("line state moved without a write");
  line_single_a: assert property (
    line_oe |-> line_dp ^ line_dm) else $error("J and K together");
  pkt_stall_a: assert property (
    byte_stalled |=> tx_valid && $stable(tx_data)) else $error("byte lost");
  pkt_pid_a: assert property (
    $rose(tx_valid) |-> tx_data == PID_DATA0) else $error("packet w/o pid");
  pkt_gap_a: assert property (
    last_taken |=> !tx_valid) else $error("no gap after packet");
  speed_source_a: assert property (
    $changed({speed_high, speed_full}) |->
      $past(s_axi_bvalid) || $rose(s_axi_bvalid))
    else $error("speed moved without a write");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rd late");
endmodule

bind usbt_test_modes usbt_properties usbt_properties_i (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .in_token, .nak_handshake, .line_oe, .line_dp, .line_dm,
  .tx_valid, .tx_data, .tx_last, .tx_ready, .speed_high, .speed_full
);
